// ==== verilog/reset_cause_pkg.sv ====
// Constants, carriers and state layout for the reset cause and start-up sequencer
package reset_cause_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_HZ = 25_000_000;
	localparam int unsigned POWERUP_TIME_US = 64;
	localparam int unsigned POWERUP_CYCLES = POWERUP_TIME_US * (CLK_HZ / 1_000_000);
	localparam int unsigned OSC_START_CYCLES = 1024;
	localparam int unsigned CNT_WIDTH = 16;
	localparam int unsigned PC_WIDTH = 15;

	// ----------------------------------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_POWER_CTL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_CONFIG = 8'h08;
	localparam logic [7:0] REG_SEQ = 8'h0C;

	// power_ctl_reg fields
	localparam int unsigned PCTL_OVER = 7;
	localparam int unsigned PCTL_UNDER = 6;
	localparam int unsigned PCTL_EXT = 3;
	localparam int unsigned PCTL_INSTR = 2;
	localparam int unsigned PCTL_POR = 1;
	localparam int unsigned PCTL_BROWN = 0;
	localparam logic [7:0] PCTL_IMPL_MASK = 8'hCF;
	localparam logic [7:0] PCTL_RESET = 8'h0C;

	// Status register fields
	localparam int unsigned STAT_EXPIRY = 4;
	localparam int unsigned STAT_SLEEP = 3;

	// Configuration register fields
	localparam int unsigned CFG_DEPTH_EN = 0;
	localparam int unsigned CFG_PWRUP_N = 1;
	localparam int unsigned CFG_PIN_EN = 2;
	localparam int unsigned CFG_OSC_NEED = 3;
	localparam logic [3:0] CFG_RESET = 4'hD;

	// Sequencer register fields
	localparam int unsigned SEQ_CORE_RESET = 8;
	localparam int unsigned SEQ_IRQ_PEND = 9;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {ST_POWERUP, ST_OSCWAIT, ST_PINWAIT, ST_HOLD, ST_RUN} seq_type;

	typedef struct packed {
		logic stack_over;
		logic stack_under;
		logic reset_instr;
		logic wdt_timeout;
		logic irq_wake;
		logic instr_retire;
		logic clrwdt;
		logic sleep_enter;
	} core_event_type;

	typedef struct packed {
		seq_type seq;
		logic [CNT_WIDTH-1:0] cnt;
		logic [7:0] power_ctl_reg;
		logic watchdog_expiry_flag_n;
		logic sleep_entry_flag_n;
		logic [3:0] cfg;
		logic pin_prev;
		logic prog_prev;
		logic brown_prev;
		logic irq_pending;
		logic core_reset;
		logic pc_load;
		logic [PC_WIDTH-1:0] pc_value;
		logic wake;
		logic vec_req;
		logic dp_write;
		logic [7:0] dp_addr;
		logic [31:0] rd_data;
		logic ready;
	} state_type;

endpackage

// ==== verilog/reset_cause_startup_seq.sv ====
// Reset cause recording and start-up sequencing with an AHB-Lite register slave
//
// Contract
// [RULE_01] Stack faults reset only when enabled
// [RULE_02] Overflow reset sets flag, zeroes PC
// [RULE_03] Underflow reset sets flag, zeroes PC
// [RULE_04] Programming exit acts as power-on
// [RULE_05] Power-up delay optional after power events
// [RULE_06] Run after delays and pin release
// [RULE_07] Delays run whatever the pin level
// [RULE_08] Expired delays: start at pin release
// [RULE_09] Every reset updates cause and status; stack, reset-instruction and awake pin resets leave status unchanged
// [RULE_10] Power-on and brown-out flag patterns
// [RULE_11] Watchdog reset or wake updates timeout
// [RULE_12] Interrupt wake: timeout set, PC+1
// [RULE_13] Enabled interrupt wake vectors after instruction
// [RULE_14] Pin reset running clears pin flag
// [RULE_15] Pin reset asleep also sets status
// [RULE_16] Reset instruction clears its flag
// [RULE_17] Unimplemented bits read as zero
// [RULE_18] Power control register bit layout
// [RULE_19] Firmware re-arms power-on, brown-out flags
// [RULE_20] Hold reset while any source pending
module reset_cause_startup_seq
	import reset_cause_pkg::*;
#(
	parameter int unsigned POWERUP_CNT = POWERUP_CYCLES,
	parameter int unsigned OSC_CNT = OSC_START_CYCLES
)
(
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Reset sources and pin
	input wire logic ext_reset_pin_n,
	input wire logic brownout_n,
	input wire logic prog_mode,
	// Core side
	input wire core_event_type core_event,
	input wire logic sleeping,
	input wire logic global_irq_en,
	input wire logic [PC_WIDTH-1:0] pc_current,
	output logic core_reset,
	output logic pc_load,
	output logic [PC_WIDTH-1:0] pc_load_value,
	output logic wake,
	output logic irq_vector_req
);

	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	// ----------------------------------------------------------------
	// Elaboration checks
	// ----------------------------------------------------------------
	if (POWERUP_CNT < 1 || POWERUP_CNT >= (1 << CNT_WIDTH))
	begin : g_bad_powerup
		$error("POWERUP_CNT out of range");
	end
	if (OSC_CNT < 1 || OSC_CNT >= (1 << CNT_WIDTH))
	begin : g_bad_osc
		$error("OSC_CNT out of range");
	end

	localparam logic [CNT_WIDTH-1:0] PWR_LAST = CNT_WIDTH'(POWERUP_CNT - 1);
	localparam logic [CNT_WIDTH-1:0] OSC_LAST = CNT_WIDTH'(OSC_CNT - 1);

	state_type s;
	state_type n;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] read_mux(input state_type st, input logic [7:0] a);
		logic [31:0] r;
		r = 32'h0000_0000;
		unique case (a)
			REG_POWER_CTL: r[7:0] = st.power_ctl_reg & PCTL_IMPL_MASK; // RULE_17
			REG_STATUS:
			begin
				r[STAT_EXPIRY] = st.watchdog_expiry_flag_n;
				r[STAT_SLEEP] = st.sleep_entry_flag_n;
			end
			REG_CONFIG: r[3:0] = st.cfg;
			REG_SEQ:
			begin
				r[2:0] = st.seq;
				r[SEQ_CORE_RESET] = st.core_reset;
				r[SEQ_IRQ_PEND] = st.irq_pending;
			end
			default: r = 32'h0000_0000;
		endcase
		return r;
	endfunction

	// Power-on pattern, called only on programming exit; supply start loads PCTL_RESET
	function automatic state_type power_on(input state_type st);
		state_type t;
		t = st;
		t.power_ctl_reg[PCTL_OVER] = 1'b0;
		t.power_ctl_reg[PCTL_UNDER] = 1'b0;
		t.power_ctl_reg[PCTL_EXT] = 1'b1;
		t.power_ctl_reg[PCTL_INSTR] = 1'b1;
		t.power_ctl_reg[PCTL_POR] = 1'b0;
		t.watchdog_expiry_flag_n = 1'b1;
		t.sleep_entry_flag_n = 1'b1;
		t.seq = ST_POWERUP;
		t.cnt = '0;
		return t;
	endfunction

	logic pin_held;
	logic running;
	logic bus_sel;
	assign pin_held = s.cfg[CFG_PIN_EN] && !ext_reset_pin_n;
	assign running = (s.seq == ST_RUN);
	assign bus_sel = hsel && htrans[1] && hready;

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	always_comb
	begin
		n = s;
		n.wake = 1'b0;
		n.vec_req = 1'b0;
		n.pin_prev = ext_reset_pin_n;
		n.prog_prev = prog_mode;
		n.brown_prev = brownout_n;

		// Software write first so hardware events below win the same cycle
		if (s.dp_write)
		begin
			unique case (s.dp_addr)
				REG_POWER_CTL: n.power_ctl_reg = hwdata[7:0] & PCTL_IMPL_MASK; // RULE_19
				REG_CONFIG: n.cfg = hwdata[3:0];
				default: n.cfg = n.cfg;
			endcase
		end

		// Reset and wake sources, highest priority first
		if (!brownout_n)
		begin
			if (s.brown_prev)
			begin
				n.power_ctl_reg[PCTL_OVER] = 1'b0; // RULE_10
				n.power_ctl_reg[PCTL_UNDER] = 1'b0;
				n.power_ctl_reg[PCTL_EXT] = 1'b1;
				n.power_ctl_reg[PCTL_INSTR] = 1'b1;
				n.power_ctl_reg[PCTL_BROWN] = 1'b0;
				n.watchdog_expiry_flag_n = 1'b1;
				n.sleep_entry_flag_n = 1'b1;
			end
			n.seq = ST_POWERUP; // RULE_20
			n.cnt = '0;
			n.irq_pending = 1'b0;
		end
		else if (s.prog_prev && !prog_mode)
		begin
			n = power_on(n); // RULE_04
			n.irq_pending = 1'b0;
		end
		else if (running && s.pin_prev && pin_held)
		begin
			n.power_ctl_reg[PCTL_EXT] = 1'b0; // RULE_14
			if (sleeping)
			begin
				n.watchdog_expiry_flag_n = 1'b1; // RULE_15
				n.sleep_entry_flag_n = 1'b0;
			end
			n.seq = ST_HOLD;
			n.irq_pending = 1'b0;
		end
		else if (running && core_event.wdt_timeout)
		begin
			n.watchdog_expiry_flag_n = 1'b0; // RULE_11
			if (sleeping)
			begin
				n.sleep_entry_flag_n = 1'b0;
				n.wake = 1'b1;
			end
			else
			begin
				n.seq = ST_HOLD;
				n.irq_pending = 1'b0;
			end
		end
		else if (running && core_event.stack_over && s.cfg[CFG_DEPTH_EN]) // RULE_01
		begin
			n.power_ctl_reg[PCTL_OVER] = 1'b1; // RULE_02
			n.seq = ST_HOLD;
			n.irq_pending = 1'b0;
		end
		else if (running && core_event.stack_under && s.cfg[CFG_DEPTH_EN]) // RULE_01
		begin
			n.power_ctl_reg[PCTL_UNDER] = 1'b1; // RULE_03
			n.seq = ST_HOLD;
			n.irq_pending = 1'b0;
		end
		else if (running && core_event.reset_instr)
		begin
			n.power_ctl_reg[PCTL_INSTR] = 1'b0; // RULE_16
			n.seq = ST_HOLD;
			n.irq_pending = 1'b0;
		end
		else if (running && sleeping && core_event.irq_wake)
		begin
			n.watchdog_expiry_flag_n = 1'b1; // RULE_12
			n.sleep_entry_flag_n = 1'b0;
			n.wake = 1'b1;
			n.irq_pending = global_irq_en; // RULE_13
		end
		else
		begin
			if (running && core_event.clrwdt)
			begin
				n.watchdog_expiry_flag_n = 1'b1; // RULE_09
				n.sleep_entry_flag_n = 1'b1;
			end
			else if (running && core_event.sleep_enter)
			begin
				n.watchdog_expiry_flag_n = 1'b1; // RULE_09
				n.sleep_entry_flag_n = 1'b0;
			end
			if (s.irq_pending && core_event.instr_retire)
			begin
				n.vec_req = 1'b1; // RULE_13
				n.irq_pending = 1'b0;
			end

			// Start-up timers ignore the pin; only the last step looks at it
			unique case (s.seq)
				ST_POWERUP:
				begin
					if (s.cfg[CFG_PWRUP_N] || s.cnt == PWR_LAST) // RULE_05 RULE_07
					begin
						n.seq = ST_OSCWAIT;
						n.cnt = '0;
					end
					else
					begin
						n.cnt = s.cnt + 1'b1;
					end
				end
				ST_OSCWAIT:
				begin
					if (!s.cfg[CFG_OSC_NEED] || s.cnt == OSC_LAST) // RULE_06 RULE_07
					begin
						n.seq = ST_PINWAIT;
						n.cnt = '0;
					end
					else
					begin
						n.cnt = s.cnt + 1'b1;
					end
				end
				ST_PINWAIT, ST_HOLD:
				begin
					if (!pin_held)
					begin
						n.seq = ST_RUN; // RULE_06 RULE_08
					end
				end
				ST_RUN: n.seq = ST_RUN;
			endcase
		end

		n.power_ctl_reg = n.power_ctl_reg & PCTL_IMPL_MASK; // RULE_17 RULE_18
		n.core_reset = (n.seq != ST_RUN); // RULE_20
		n.pc_load = n.core_reset || n.wake;
		n.pc_value = n.wake ? PC_WIDTH'(pc_current + 1'b1) : '0;

		// Bus: capture address phase; read data is taken after this cycle's write
		n.dp_write = bus_sel && hwrite;
		n.dp_addr = haddr[7:0];
		n.rd_data = (bus_sel && !hwrite) ? read_mux(n, haddr[7:0]) : 32'h0000_0000;
		n.ready = 1'b1;
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			s.seq <= ST_POWERUP;
			s.cnt <= '0;
			s.power_ctl_reg <= PCTL_RESET; // RULE_10
			s.watchdog_expiry_flag_n <= 1'b1;
			s.sleep_entry_flag_n <= 1'b1;
			s.cfg <= CFG_RESET;
			s.pin_prev <= 1'b1;
			s.prog_prev <= 1'b0;
			s.brown_prev <= 1'b1;
			s.irq_pending <= 1'b0;
			s.core_reset <= 1'b1;
			s.pc_load <= 1'b1;
			s.pc_value <= '0;
			s.wake <= 1'b0;
			s.vec_req <= 1'b0;
			s.dp_write <= 1'b0;
			s.dp_addr <= 8'h00;
			s.rd_data <= 32'h0000_0000;
			s.ready <= 1'b1;
		end
		else
		begin
			s <= n;
		end
	end

	assign hreadyout = s.ready;
	assign hresp = 1'b0;
	assign hrdata = s.rd_data;
	assign core_reset = s.core_reset;
	assign pc_load = s.pc_load;
	assign pc_load_value = s.pc_value;
	assign wake = s.wake;
	assign irq_vector_req = s.vec_req;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	logic quiet;
	assign quiet = brownout_n && !(s.prog_prev && !prog_mode) && !(s.pin_prev && pin_held);

	property p_depth_gate;
		running && quiet && !pin_held && !core_event.wdt_timeout && !core_event.reset_instr
			&& !s.cfg[CFG_DEPTH_EN] && (core_event.stack_over || core_event.stack_under)
			|=> !core_reset;
	endproperty
	a_depth_gate: assert property (p_depth_gate) else $error("stack fault reset while disabled"); // RULE_01

	property p_over;
		running && quiet && !core_event.wdt_timeout && s.cfg[CFG_DEPTH_EN] && core_event.stack_over
			|=> s.power_ctl_reg[PCTL_OVER] && core_reset && pc_load && pc_load_value == '0;
	endproperty
	a_over: assert property (p_over) else $error("overflow reset wrong"); // RULE_02

	property p_under;
		running && quiet && !core_event.wdt_timeout && s.cfg[CFG_DEPTH_EN]
			&& !core_event.stack_over && core_event.stack_under
			|=> s.power_ctl_reg[PCTL_UNDER] && core_reset && pc_load_value == '0;
	endproperty
	a_under: assert property (p_under) else $error("underflow reset wrong"); // RULE_03

	property p_prog_exit;
		brownout_n && s.prog_prev && !prog_mode
			|=> s.power_ctl_reg[3:1] == 3'b110 && s.watchdog_expiry_flag_n
			&& s.sleep_entry_flag_n && s.seq == ST_POWERUP;
	endproperty
	a_prog_exit: assert property (p_prog_exit) else $error("programming exit not power-on"); // RULE_04

	property p_powerup_len;
		s.seq == ST_POWERUP && !s.cfg[CFG_PWRUP_N] && s.cnt < PWR_LAST && quiet
			|=> s.seq == ST_POWERUP && core_reset;
	endproperty
	a_powerup_len: assert property (p_powerup_len) else $error("power-up delay cut short"); // RULE_05

	property p_pin_indep;
		s.seq == ST_POWERUP && !s.cfg[CFG_PWRUP_N] && s.cnt == PWR_LAST && quiet
			|=> s.seq == ST_OSCWAIT;
	endproperty
	a_pin_indep: assert property (p_pin_indep) else $error("power-up delay stalled by pin"); // RULE_07

	property p_pin_release;
		s.seq == ST_PINWAIT && quiet && !pin_held |=> !core_reset;
	endproperty
	a_pin_release: assert property (p_pin_release) else $error("no start at pin release"); // RULE_08

	property p_brownout;
		s.brown_prev && !brownout_n
			|=> !s.power_ctl_reg[PCTL_BROWN]
			&& s.power_ctl_reg[PCTL_POR] == $past(s.power_ctl_reg[PCTL_POR])
			&& core_reset;
	endproperty
	a_brownout: assert property (p_brownout) else $error("brown-out flags wrong"); // RULE_10

	property p_wdt_wake;
		running && quiet && sleeping && core_event.wdt_timeout
			|=> !s.watchdog_expiry_flag_n && !s.sleep_entry_flag_n && wake
			&& pc_load_value == $past(pc_current) + 1'b1;
	endproperty
	a_wdt_wake: assert property (p_wdt_wake) else $error("watchdog wake wrong"); // RULE_11

	property p_irq_arm;
		running && quiet && sleeping && global_irq_en && core_event.irq_wake
			&& !core_event.wdt_timeout && !core_event.stack_over && !core_event.stack_under
			&& !core_event.reset_instr
			|=> s.irq_pending && wake && s.watchdog_expiry_flag_n && !s.sleep_entry_flag_n
			&& pc_load_value == $past(pc_current) + 1'b1;
	endproperty
	a_irq_arm: assert property (p_irq_arm) else $error("interrupt wake wrong"); // RULE_12

	// Vector follows the first retired instruction once a wake has armed it
	property p_irq_vector;
		running && quiet && s.irq_pending && core_event.instr_retire
			&& !core_event.wdt_timeout && !core_event.stack_over && !core_event.stack_under
			&& !core_event.reset_instr && !(sleeping && core_event.irq_wake)
			|=> irq_vector_req;
	endproperty
	a_irq_vector: assert property (p_irq_vector) else $error("no vector after wake"); // RULE_13

	property p_pin_reset;
		running && brownout_n && !(s.prog_prev && !prog_mode) && s.pin_prev && pin_held
			|=> (!s.power_ctl_reg[PCTL_EXT] && core_reset && pc_load && pc_load_value == '0)
			##1 (core_reset || !$past(pin_held));
	endproperty
	a_pin_reset: assert property (p_pin_reset) else $error("pin reset wrong"); // RULE_14

	property p_unimpl;
		s.power_ctl_reg[5:4] == 2'b00;
	endproperty
	a_unimpl: assert property (p_unimpl) else $error("unimplemented bits set"); // RULE_17

endmodule

// ==== tb/pin_supply_model.sv ====
// Reset pin driver and supply monitor standing outside the sequencer
module pin_supply_model
(
	// Clock
	input wire logic hclk,
	// Requests from the bench
	input wire logic pin_low_req,
	input wire logic brown_req,
	input wire logic prog_req,
	// Pins towards the device
	output logic ext_reset_pin_n,
	output logic brownout_n,
	output logic prog_mode
);
	timeunit 1ns;
	timeprecision 1ps;

	// Pin held low from power-up until the bench lets go
	initial ext_reset_pin_n = 1'b0;
	initial brownout_n = 1'b1;
	initial prog_mode = 1'b0;

	// Weak pull-up returns the pin high once released
	always @(posedge hclk)
	begin
		ext_reset_pin_n <= !pin_low_req;
		brownout_n <= !brown_req;
		prog_mode <= prog_req;
	end
endmodule

// ==== tb/reset_cause_startup_seq_bench.sv ====
// Self-checking bench for the reset cause and start-up sequencer
module reset_cause_startup_seq_bench
	import reset_cause_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [1:0] htrans = 2'b00;
	logic [2:0] hsize = 3'b010;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	logic pin_low_req = 1'b1;
	logic brown_req = 1'b0;
	logic prog_req = 1'b0;
	logic ext_reset_pin_n, brownout_n, prog_mode;
	core_event_type core_event = '0;
	logic sleeping = 1'b0;
	logic global_irq_en = 1'b0;
	logic [PC_WIDTH-1:0] pc_current = 15'h1234;
	logic [PC_WIDTH-1:0] pc_load_value;
	logic core_reset, pc_load, wake, irq_vector_req;
	int miscompares = 0;
	int tests_run = 0;
	int cycles = 0;

	initial forever #20 hclk = ~hclk;

	pin_supply_model partner (.hclk(hclk), .pin_low_req(pin_low_req), .brown_req(brown_req),
		.prog_req(prog_req), .ext_reset_pin_n(ext_reset_pin_n), .brownout_n(brownout_n),
		.prog_mode(prog_mode));

	// Short delays keep the run brief
	reset_cause_startup_seq #(.POWERUP_CNT(4), .OSC_CNT(3)) dut (.hclk(hclk),
		.hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .ext_reset_pin_n(ext_reset_pin_n), .brownout_n(brownout_n),
		.prog_mode(prog_mode), .core_event(core_event), .sleeping(sleeping),
		.global_irq_en(global_irq_en), .pc_current(pc_current), .core_reset(core_reset),
		.pc_load(pc_load), .pc_load_value(pc_load_value), .wake(wake),
		.irq_vector_req(irq_vector_req));

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task end_sim;
		$display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
			miscompares++;
		end
	endtask

	// Waits for hready at a rising edge; read data is taken at that same edge
	task hs(output logic [31:0] r);
		do
			@(posedge hclk);
		while (hreadyout !== 1'b1);
		r = hrdata;
	endtask

	task bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'b10;
		hwrite <= w;
		hs(r);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		hs(r);
		chk(32'(hresp), 32'h0);
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
	endtask

	task rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] r;
		bus(1'b0, a, 32'h0, r);
		chk(r, exp);
	endtask

	task ev(input core_event_type e);
		@(posedge hclk);
		core_event <= e;
		@(posedge hclk);
		core_event <= '0;
		#1;
	endtask

	task wait_run;
		int n;
		n = 0;
		while (core_reset !== 1'b0 && n < 200)
		begin
			@(posedge hclk);
			#1;
			n++;
		end
		chk(32'(core_reset), 32'h0);
	endtask

	// Mask order: programming mode, brown-out, pin low
	task pulse_src(input logic [2:0] m);
		@(posedge hclk);
		{prog_req, brown_req, pin_low_req} <= m;
		repeat (3) @(posedge hclk);
		#1;
		if (m != 3'b100)
			chk(32'(core_reset), 32'h1);
		@(posedge hclk);
		{prog_req, brown_req, pin_low_req} <= 3'b000;
		repeat (3) @(posedge hclk);
		wait_run;
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task s_start;
		int n;
		repeat (20) @(posedge hclk);
		rd(REG_SEQ, 32'h102);
		rd(REG_POWER_CTL, 32'h0C);
		rd(REG_STATUS, 32'h18);
		rd(8'h10, 32'h0);
		@(posedge hclk);
		pin_low_req <= 1'b0;
		n = 0;
		while (core_reset !== 1'b0 && n < 20)
		begin
			@(posedge hclk);
			#1;
			n++;
		end
		chk(32'(n <= 3), 32'h1);
		rd(REG_SEQ, 32'h004);
	endtask

	task s_stack;
		wr(REG_CONFIG, 32'h0C);
		ev(8'h80);
		chk(32'(core_reset), 32'h0);
		wr(REG_CONFIG, 32'h0D);
		ev(8'h80);
		chk(32'({core_reset, pc_load, pc_load_value}), 32'h18000);
		wait_run;
		rd(REG_POWER_CTL, 32'h8C);
		ev(8'h40);
		chk(32'({core_reset, pc_load_value}), 32'h8000);
		wait_run;
		rd(REG_POWER_CTL, 32'hCC);
	endtask

	task s_instr;
		wr(REG_POWER_CTL, 32'hFF);
		rd(REG_POWER_CTL, 32'hCF);
		wr(REG_POWER_CTL, 32'h0F);
		ev(8'h20);
		chk(32'(core_reset), 32'h1);
		wait_run;
		rd(REG_POWER_CTL, 32'h0B);
		wr(REG_POWER_CTL, 32'h0F);
		pulse_src(3'b001);
		rd(REG_POWER_CTL, 32'h07);
		rd(REG_STATUS, 32'h18);
		ev(8'h10);
		chk(32'({core_reset, pc_load_value}), 32'h8000);
		wait_run;
		rd(REG_STATUS, 32'h08);
	endtask

	task s_sleep;
		sleeping <= 1'b1;
		global_irq_en <= 1'b1;
		ev(8'h08);
		chk(32'({wake, pc_load, pc_load_value}), 32'h19235);
		@(posedge hclk);
		sleeping <= 1'b0;
		rd(REG_STATUS, 32'h10);
		ev(8'h04);
		chk(32'(irq_vector_req), 32'h1);
		@(posedge hclk);
		sleeping <= 1'b1;
		ev(8'h10);
		chk(32'({core_reset, wake, pc_load_value}), 32'h09235);
		rd(REG_STATUS, 32'h00);
		wr(REG_POWER_CTL, 32'h0F);
		pulse_src(3'b001);
		@(posedge hclk);
		sleeping <= 1'b0;
		rd(REG_STATUS, 32'h10);
		rd(REG_POWER_CTL, 32'h07);
	endtask

	task s_power;
		wr(REG_POWER_CTL, 32'h0F);
		pulse_src(3'b010);
		rd(REG_POWER_CTL, 32'h0E);
		rd(REG_STATUS, 32'h18);
		wr(REG_POWER_CTL, 32'h0F);
		pulse_src(3'b100);
		rd(REG_POWER_CTL, 32'h0D);
		rd(REG_STATUS, 32'h18);
	endtask

	// ----------------------------------------------------------------
	// Main sequence and watchdog on the run
	// ----------------------------------------------------------------
	always @(posedge hclk)
	begin
		cycles <= cycles + 1;
		if (cycles == 5000)
		begin
			miscompares++;
			end_sim;
		end
	end

	initial
	begin
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		s_start;
		s_stack;
		s_instr;
		s_sleep;
		s_power;
		end_sim;
	end
endmodule
